// [rtl/reset_source_pkg.sv]
// Constants, register map and carrier types of the reset source controller.
package reset_source_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int MIN_PULSE_NS    = 150;
	localparam int PRECISE_SUPPLY_MONITOR_HOLD_NS    = 10000;
	localparam int PULSE_CYC       = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int PRECISE_SUPPLY_MONITOR_HOLD_CYC   = (PRECISE_SUPPLY_MONITOR_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_W         = $clog2(PULSE_CYC + 1);
	localparam int HOLD_W          = $clog2(PRECISE_SUPPLY_MONITOR_HOLD_CYC + 1);
	localparam int BUZZ_ON_CYC     = 8;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_SOFT     = 8'h04;
	localparam logic [7:0] OFS_WDT_TMO  = 8'h08;
	localparam logic [7:0] OFS_WDT_KICK = 8'h0C;
	localparam logic [7:0] OFS_BUZZ     = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_IRQ      = 8'h18;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTL_WDT_EN    = 0;
	localparam int CTL_SOFT_BLK  = 1;
	localparam int CTL_ALOW_RST  = 2;
	localparam int CTL_DLOW_RST  = 3;
	localparam int CTL_AREG_OFF  = 4;
	localparam int CTL_ATRIP_LSB = 8;
	localparam int CTL_DTRIP_LSB = 12;
	localparam int CTL_IRQEN_LSB = 16;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ST_PRECISE_SUPPLY_MONITOR = 0;
	localparam int ST_EXT  = 1;
	localparam int ST_WDT  = 2;
	localparam int ST_SOFT = 3;
	localparam int ST_LVR  = 4;
	localparam int ST_IRQ0 = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] WDT_TMO_RST = 32'h0000_FFFF;
	localparam logic [15:0] BUZZ_RST    = 16'h03E8;
	localparam logic [3:0]  TRIP_RST    = 4'h0;

	typedef struct packed {
		logic [2:0] irqEn;
		logic [3:0] dTrip;
		logic [3:0] aTrip;
		logic       anaRegOff;
		logic       dLowRst;
		logic       aLowRst;
		logic       softBlock;
		logic       wdtEn;
	} ctrl_t;

	typedef struct packed {
		logic initPor;
		logic presDig;
		logic presAna;
		logic aHigh;
		logic dLow;
		logic aLow;
		logic extRstN;
	} trips_t;

endpackage

// [rtl/bit_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module bit_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// Levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output      logic [WIDTH-1:0] syncOut
);

	if (WIDTH < 1) begin : g_width_chk
		$error("bit_sync needs a WIDTH of at least one.");
	end

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_t;

	sync_t st_q;
	sync_t st_d;

	always_comb begin
		st_d.meta   = asyncIn;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= {RST_VAL, RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign syncOut = st_q.stable;

endmodule // bit_sync

// [rtl/reset_source_controller.sv]
// Reset source controller: combines supply, pin, watchdog and software resets.
// Operation
// - Out-of-range precise comparators cause a device reset; low-voltage ones only when set to, high-voltage never.
// - Supply monitors can raise an interrupt before the reset thresholds.
// - Device is held in reset while the external reset input is low.
// - Watchdog resets the device when not restarted within the timeout.
// - Watchdog enable is set-only; only power-on reset clears it.
// - Setting the software reset bit causes a device reset.
// - A blocking bit stops the software reset bit from acting.
// - Device reset returns all registers except watchdog enable and reset-cause status to their reset state.
// - Reset-cause status records events; only power-on reset clears it.
// - Reset pulse is at least 150 ns, longer while supplies ramp.
// - After boot the power-on detector hands off to the precise monitor.
// - Precise monitor trip resets; no reassertion within 10 us of release.
// - Digital precise part cannot be disabled; analog part follows regulator.
// - Precise monitor off in sleep and hibernate, except sleep buzz intervals.
// - Low trip levels are programmable in steps; high trip is fixed.
// - Each low-voltage detector may cause a reset instead of an interrupt.
// - Monitors idle until power-on ends; sleep interrupts wake first.
// - Sleep buzz interval is programmable.
// - External reset works in sleep and hibernate.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module reset_source_controller (
	// Clock and power-on reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// Pins and supply comparators
	input  wire logic        ext_reset_n,
	input  wire logic        initial_power_on_detect,
	input  wire logic        precise_supply_monitor_dig,
	input  wire logic        precise_supply_monitor_ana,
	input  wire logic        analog_low_volt_irq,
	input  wire logic        digital_low_volt_irq,
	input  wire logic        analog_high_volt_irq,
	// Power manager
	input  wire logic        bootDone,
	input  wire logic        sleepMode,
	input  wire logic        hibernateMode,
	// Outputs
	output      logic        deviceResetN,
	output      logic        supplyIrq,
	output      logic        wakeupReq,
	output      logic        presEnable,
	output      logic [3:0]  analogTripLevel,
	output      logic [3:0]  digitalTripLevel
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		reset_source_pkg::ctrl_t                    ctrl;
		logic [31:0]                                wdtTmo;
		logic [31:0]                                wdtCnt;
		logic [15:0]                                buzzIntv;
		logic [15:0]                                buzzCnt;
		logic [3:0]                                 buzzOn;
		logic                                       softReq;
		logic [7:0]                                 status;
		logic [2:0]                                 irqFlags;
		logic                                       presPrev;
		logic [reset_source_pkg::HOLD_W-1:0]        holdCnt;
		logic [reset_source_pkg::PULSE_W-1:0]       pulseCnt;
		logic [1:0]                                 relStage;
		logic                                       supplyIrq;
		logic                                       wakeupReq;
		logic                                       presEn;
		logic                                       pready;
		logic                                       pslverr;
		logic [31:0]                                prdata;
	} state_t;

	state_t                   st_q;
	state_t                   st_d;
	reset_source_pkg::trips_t trips;
	logic                     monActive;
	logic                     presRaw;
	logic                     presTrip;
	logic                     lowRst;
	logic                     wdtExpire;
	logic                     softFire;
	logic                     resetReq;
	logic                     active;
	logic [2:0]               lviTrip;
	logic                     busWr;
	logic                     busRd;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// The pin stage starts at its idle high level, so power-on records no false pin reset.
	bit_sync #(
		.WIDTH   (7),
		.RST_VAL (7'h01)
	) u_trip_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.asyncIn ({initial_power_on_detect, precise_supply_monitor_dig,
			precise_supply_monitor_ana, analog_high_volt_irq,
			digital_low_volt_irq, analog_low_volt_irq, ext_reset_n}),
		.syncOut (trips)
	);

	// ----------------------------------------------------------------
	// Source qualification
	// ----------------------------------------------------------------
	always_comb begin
		// Monitors idle until boot, and in low power except while buzzing.
		monActive = bootDone && ((!sleepMode && !hibernateMode)
			|| (sleepMode && !hibernateMode && st_q.buzzOn != 4'h0));
		// Digital part always armed; analog part follows the regulator.
		presRaw   = trips.presDig || (trips.presAna && !st_q.ctrl.anaRegOff);
		presTrip  = presRaw && monActive && st_q.holdCnt == '0;
		lviTrip   = {trips.aHigh, trips.dLow, trips.aLow} & {3{monActive}};
		lowRst    = (lviTrip[0] && st_q.ctrl.aLowRst)
			|| (lviTrip[1] && st_q.ctrl.dLowRst);
		wdtExpire = st_q.ctrl.wdtEn && st_q.wdtCnt >= st_q.wdtTmo;
		softFire  = st_q.softReq && !st_q.ctrl.softBlock;
		resetReq  = presTrip || lowRst || wdtExpire || softFire
			|| !trips.extRstN
			|| (trips.initPor && !bootDone);
		active    = resetReq || st_q.pulseCnt != '0;
		busWr     = psel && penable && pwrite && st_q.pready;
		busRd     = psel && penable && !pwrite && !st_q.pready;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// Reset stretch and two-stage synchronous release.
		if (resetReq) begin
			st_d.pulseCnt = reset_source_pkg::PULSE_W'(reset_source_pkg::PULSE_CYC);
		end else if (st_q.pulseCnt != '0) begin
			st_d.pulseCnt = st_q.pulseCnt - 1'b1;
		end
		if (active) begin
			st_d.relStage = 2'b00;
		end else begin
			st_d.relStage = {st_q.relStage[0], 1'b1};
		end

		// Hold-off after the precise monitor lets go.
		st_d.presPrev = presTrip;
		if (st_q.presPrev && !presTrip) begin
			st_d.holdCnt = reset_source_pkg::HOLD_W'(reset_source_pkg::PRECISE_SUPPLY_MONITOR_HOLD_CYC);
		end else if (st_q.holdCnt != '0) begin
			st_d.holdCnt = st_q.holdCnt - 1'b1;
		end

		// Sleep buzz timer.
		if (!sleepMode || hibernateMode) begin
			st_d.buzzCnt = 16'h0000;
			st_d.buzzOn  = 4'h0;
		end else if (st_q.buzzOn != 4'h0) begin
			st_d.buzzOn = st_q.buzzOn - 4'h1;
		end else if (st_q.buzzCnt >= st_q.buzzIntv) begin
			st_d.buzzCnt = 16'h0000;
			st_d.buzzOn  = 4'(reset_source_pkg::BUZZ_ON_CYC);
		end else begin
			st_d.buzzCnt = st_q.buzzCnt + 16'h0001;
		end
		st_d.presEn = monActive;

		// Watchdog counter.
		if (!st_q.ctrl.wdtEn || !st_q.relStage[1]) begin
			st_d.wdtCnt = 32'h0000_0000;
		end else if (!wdtExpire) begin
			st_d.wdtCnt = st_q.wdtCnt + 32'h0000_0001;
		end

		// Sticky cause and interrupt flags; a new event beats a software clear.
		if (presTrip) begin
			st_d.status[reset_source_pkg::ST_PRECISE_SUPPLY_MONITOR] = 1'b1;
		end
		if (!trips.extRstN) begin
			st_d.status[reset_source_pkg::ST_EXT] = 1'b1;
		end
		if (wdtExpire) begin
			st_d.status[reset_source_pkg::ST_WDT] = 1'b1;
		end
		if (softFire) begin
			st_d.status[reset_source_pkg::ST_SOFT] = 1'b1;
		end
		if (lowRst) begin
			st_d.status[reset_source_pkg::ST_LVR] = 1'b1;
		end

		// APB access: read data on the first access edge, write on the second.
		st_d.pready  = psel && penable && !st_q.pready;
		st_d.pslverr = 1'b0;
		if (busRd) begin
			st_d.prdata = 32'h0000_0000;
			if (paddr == reset_source_pkg::OFS_CTRL) begin
				st_d.prdata[reset_source_pkg::CTL_WDT_EN]   = st_q.ctrl.wdtEn;
				st_d.prdata[reset_source_pkg::CTL_SOFT_BLK] = st_q.ctrl.softBlock;
				st_d.prdata[reset_source_pkg::CTL_ALOW_RST] = st_q.ctrl.aLowRst;
				st_d.prdata[reset_source_pkg::CTL_DLOW_RST] = st_q.ctrl.dLowRst;
				st_d.prdata[reset_source_pkg::CTL_AREG_OFF] = st_q.ctrl.anaRegOff;
				st_d.prdata[reset_source_pkg::CTL_ATRIP_LSB +: 4] = st_q.ctrl.aTrip;
				st_d.prdata[reset_source_pkg::CTL_DTRIP_LSB +: 4] = st_q.ctrl.dTrip;
				st_d.prdata[reset_source_pkg::CTL_IRQEN_LSB +: 3] = st_q.ctrl.irqEn;
			end else if (paddr == reset_source_pkg::OFS_SOFT) begin
				st_d.prdata[0] = st_q.softReq;
			end else if (paddr == reset_source_pkg::OFS_WDT_TMO) begin
				st_d.prdata = st_q.wdtTmo;
			end else if (paddr == reset_source_pkg::OFS_WDT_KICK) begin
				st_d.prdata = st_q.wdtCnt;
			end else if (paddr == reset_source_pkg::OFS_BUZZ) begin
				st_d.prdata[15:0] = st_q.buzzIntv;
			end else if (paddr == reset_source_pkg::OFS_STATUS) begin
				st_d.prdata[7:0] = st_q.status;
			end else if (paddr == reset_source_pkg::OFS_IRQ) begin
				st_d.prdata[2:0] = st_q.irqFlags;
			end else begin
				st_d.pslverr = 1'b1;
			end
		end else if (psel && penable && pwrite && !st_q.pready) begin
			st_d.pslverr = !(paddr == reset_source_pkg::OFS_CTRL
				|| paddr == reset_source_pkg::OFS_SOFT
				|| paddr == reset_source_pkg::OFS_WDT_TMO
				|| paddr == reset_source_pkg::OFS_WDT_KICK
				|| paddr == reset_source_pkg::OFS_BUZZ
				|| paddr == reset_source_pkg::OFS_STATUS
				|| paddr == reset_source_pkg::OFS_IRQ);
		end else if (st_q.pready) begin
			st_d.pslverr = st_q.pslverr;
		end

		if (busWr) begin
			if (paddr == reset_source_pkg::OFS_CTRL) begin
				// Zero writes to the watchdog enable are ignored.
				st_d.ctrl.wdtEn     = st_q.ctrl.wdtEn
					|| pwdata[reset_source_pkg::CTL_WDT_EN];
				st_d.ctrl.softBlock = pwdata[reset_source_pkg::CTL_SOFT_BLK];
				st_d.ctrl.aLowRst   = pwdata[reset_source_pkg::CTL_ALOW_RST];
				st_d.ctrl.dLowRst   = pwdata[reset_source_pkg::CTL_DLOW_RST];
				st_d.ctrl.anaRegOff = pwdata[reset_source_pkg::CTL_AREG_OFF];
				st_d.ctrl.aTrip = pwdata[reset_source_pkg::CTL_ATRIP_LSB +: 4];
				st_d.ctrl.dTrip = pwdata[reset_source_pkg::CTL_DTRIP_LSB +: 4];
				st_d.ctrl.irqEn = pwdata[reset_source_pkg::CTL_IRQEN_LSB +: 3];
			end else if (paddr == reset_source_pkg::OFS_SOFT) begin
				st_d.softReq = pwdata[0];
			end else if (paddr == reset_source_pkg::OFS_WDT_TMO) begin
				st_d.wdtTmo = pwdata;
			end else if (paddr == reset_source_pkg::OFS_WDT_KICK) begin
				st_d.wdtCnt = 32'h0000_0000;
			end else if (paddr == reset_source_pkg::OFS_BUZZ) begin
				st_d.buzzIntv = pwdata[15:0];
			end else if (paddr == reset_source_pkg::OFS_IRQ) begin
				st_d.irqFlags = st_q.irqFlags & ~pwdata[2:0];
			end
		end

		// Interrupt-mode detectors set their flags after a software clear, before the device reset clear.
		for (int i = 0; i < 3; i++) begin
			if (lviTrip[i] && !(i == 0 && st_q.ctrl.aLowRst)
				&& !(i == 1 && st_q.ctrl.dLowRst)) begin
				st_d.irqFlags[i] = 1'b1;
				st_d.status[reset_source_pkg::ST_IRQ0 + i] = 1'b1;
			end
		end

		// In sleep, ask for wakeup first; the interrupt follows once awake.
		st_d.wakeupReq = sleepMode && |(st_q.irqFlags & st_q.ctrl.irqEn);
		st_d.supplyIrq = !sleepMode && !hibernateMode
			&& |(st_q.irqFlags & st_q.ctrl.irqEn);

		// A device reset returns the controls here to defaults.
		if (!st_q.relStage[1]) begin
			st_d.ctrl.softBlock = 1'b0;
			st_d.ctrl.aLowRst   = 1'b0;
			st_d.ctrl.dLowRst   = 1'b0;
			st_d.ctrl.anaRegOff = 1'b0;
			st_d.ctrl.aTrip     = reset_source_pkg::TRIP_RST;
			st_d.ctrl.dTrip     = reset_source_pkg::TRIP_RST;
			st_d.ctrl.irqEn     = 3'h0;
			st_d.softReq        = 1'b0;
			st_d.wdtTmo         = reset_source_pkg::WDT_TMO_RST;
			st_d.buzzIntv       = reset_source_pkg::BUZZ_RST;
			st_d.irqFlags       = 3'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q          <= '0;
			st_q.pulseCnt <= reset_source_pkg::PULSE_W'(reset_source_pkg::PULSE_CYC);
			st_q.wdtTmo   <= reset_source_pkg::WDT_TMO_RST;
			st_q.buzzIntv <= reset_source_pkg::BUZZ_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign deviceResetN     = st_q.relStage[1];
	assign supplyIrq        = st_q.supplyIrq;
	assign wakeupReq        = st_q.wakeupReq;
	assign presEnable       = st_q.presEn;
	assign analogTripLevel  = st_q.ctrl.aTrip;
	assign digitalTripLevel = st_q.ctrl.dTrip;
	assign prdata           = st_q.prdata;
	assign pready           = st_q.pready;
	assign pslverr          = st_q.pslverr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence lowFor15;
		(!deviceResetN)[*8] ##1 (!deviceResetN)[*7];
	endsequence

	supply_trip_a: assert property (presTrip |=> !deviceResetN)
		else $error("Precise monitor trip did not reset the device.");
	pin_hold_a: assert property (!trips.extRstN |=> !deviceResetN)
		else $error("External reset low but device not in reset.");
	wdt_expire_a: assert property (wdtExpire |=> !deviceResetN)
		else $error("Watchdog expiry did not reset the device.");
	wdt_sticky_a: assert property (st_q.ctrl.wdtEn |=> st_q.ctrl.wdtEn)
		else $error("Watchdog enable cleared without power-on reset.");
	soft_block_a: assert property ((st_q.ctrl.softBlock && st_q.softReq
		&& deviceResetN && st_q.relStage[0] && trips.extRstN
		&& !(trips.initPor && !bootDone) && !presTrip && !lowRst && !wdtExpire
		&& st_q.pulseCnt == '0) |=> deviceResetN)
		else $error("Blocked software reset still fired.");
	status_keep_a: assert property (($past(st_q.status) & ~st_q.status) == 8'h00)
		else $error("Reset status bit cleared.");
	pulse_width_a: assert property ($fell(deviceResetN) |-> lowFor15)
		else $error("Device reset pulse shorter than 150 ns.");
	precise_supply_monitor_hold_a: assert property ($fell(presTrip)
		|=> st_q.holdCnt == reset_source_pkg::HOLD_W'(reset_source_pkg::PRECISE_SUPPLY_MONITOR_HOLD_CYC))
		else $error("Precise monitor hold-off not armed on release.");
	hib_off_a: assert property (hibernateMode |=> !presEnable)
		else $error("Precise monitor enabled in hibernate.");
	sleep_irq_a: assert property (sleepMode |=> !supplyIrq)
		else $error("Supply interrupt presented while asleep.");
	sync_release_a: assert property ($rose(deviceResetN)
		|-> !$past(active, 1) && !$past(active, 2))
		else $error("Reset released without two quiet stages.");

endmodule // reset_source_controller

// [dv/supply_env_model.sv]
// Model of the external reset driver and the on-chip supply comparators.
`timescale 1ns/1ps
module supply_env_model #(
	parameter int GAP_CYC = 1000
) (
	// Clock
	input  wire logic                ref_clk,
	// Pin and comparator levels
	output reset_source_pkg::trips_t trips
);
	int cyc     = 0;
	int lastRel = -GAP_CYC;

	initial trips = 7'h01;

	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic setTrip(input int idx, input logic v);
		@(posedge ref_clk);
		trips[idx] <= v;
	endtask

	task automatic extPulse(input int lowCyc);
		while (cyc - lastRel < GAP_CYC) @(posedge ref_clk); // Waits out the re-arm gap.
		@(posedge ref_clk);
		trips.extRstN <= 1'b0;
		repeat (lowCyc) @(posedge ref_clk);
		trips.extRstN <= 1'b1;
		lastRel = cyc;
	endtask
endmodule // supply_env_model

// [dv/tb_reset_source_controller.sv]
// Self-checking testbench of the reset source controller.
`timescale 1ns/1ps
module tb_reset_source_controller;
	logic                     ref_clk = 1'b0;
	logic                     nrst = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [7:0]               paddr = 8'h00;
	logic [31:0]              pwdata = 32'h0;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     bootDone = 1'b0;
	logic                     sleepMode = 1'b0;
	logic                     hibernateMode = 1'b0;
	logic                     deviceResetN;
	logic                     supplyIrq;
	logic                     wakeupReq;
	logic                     presEnable;
	logic [3:0]               analogTripLevel;
	logic [3:0]               digitalTripLevel;
	reset_source_pkg::trips_t trips;
	logic [31:0]              rd;
	logic                     err;
	int                       fails = 0;
	int                       nChecks = 0;

	always #5 ref_clk = ~ref_clk;

	supply_env_model env (.ref_clk(ref_clk), .trips(trips));

	reset_source_controller dut (
		.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_reset_n(trips.extRstN), .initial_power_on_detect(trips.initPor),
		.precise_supply_monitor_dig(trips.presDig), .precise_supply_monitor_ana(trips.presAna),
		.analog_low_volt_irq(trips.aLow), .digital_low_volt_irq(trips.dLow),
		.analog_high_volt_irq(trips.aHigh), .bootDone(bootDone), .sleepMode(sleepMode),
		.hibernateMode(hibernateMode), .deviceResetN(deviceResetN), .supplyIrq(supplyIrq),
		.wakeupReq(wakeupReq), .presEnable(presEnable), .analogTripLevel(analogTripLevel),
		.digitalTripLevel(digitalTripLevel));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) check("pready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic waitLvl(input logic v, input int maxc, input string nm);
		int n;
		n = 0;
		while (deviceResetN !== v && n < maxc) begin
			@(posedge ref_clk);
			n++;
		end
		check(nm, deviceResetN, v);
	endtask

	task automatic stay(input logic v, input int c, input string nm);
		logic ok;
		ok = 1'b1;
		repeat (c) begin
			@(posedge ref_clk);
			if (deviceResetN !== v) ok = 1'b0;
		end
		check(nm, ok, 1'b1);
	endtask

	task automatic statusBit(input int b, input string nm);
		apb(1'b0, reset_source_pkg::OFS_STATUS, 32'h0);
		check(nm, rd[b], 1'b1);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		waitLvl(1'b1, 40, "release");
		apb(1'b0, reset_source_pkg::OFS_WDT_TMO, 32'h0);
		check("tmo reset", rd, reset_source_pkg::WDT_TMO_RST);
		apb(1'b0, reset_source_pkg::OFS_BUZZ, 32'h0);
		check("buzz reset", rd[15:0], reset_source_pkg::BUZZ_RST);
		apb(1'b0, reset_source_pkg::OFS_CTRL, 32'h0);
		check("wdt en off", rd[0], 1'b0);
		apb(1'b0, 8'h1C, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		env.setTrip(6, 1'b1);
		env.setTrip(6, 1'b0);
		waitLvl(1'b0, 8, "por pulse");
		stay(1'b0, 14, "por width");
		waitLvl(1'b1, 30, "por end");
		bootDone <= 1'b1;
		env.setTrip(6, 1'b1);
		stay(1'b1, 12, "por off");
		env.setTrip(6, 1'b0);
		$display("test power-on done");

		env.extPulse(40);
		check("ext hold", deviceResetN, 1'b0);
		stay(1'b0, 14, "ext stretch");
		waitLvl(1'b1, 10, "ext end");
		statusBit(reset_source_pkg::ST_EXT, "st ext");
		$display("test external done");

		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h2);
		apb(1'b1, reset_source_pkg::OFS_SOFT, 32'h1);
		stay(1'b1, 12, "soft blocked");
		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, reset_source_pkg::OFS_SOFT, 32'h1);
		waitLvl(1'b0, 8, "soft reset");
		waitLvl(1'b1, 40, "soft end");
		statusBit(reset_source_pkg::ST_SOFT, "st soft");
		check("st kept", rd[reset_source_pkg::ST_EXT], 1'b1);
		$display("test software done");

		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h0001_3500);
		@(posedge ref_clk);
		check("trip code", analogTripLevel, 4'h5);
		check("dtrip code", digitalTripLevel, 4'h3);
		env.setTrip(1, 1'b1);
		repeat (8) @(posedge ref_clk);
		check("irq up", supplyIrq, 1'b1);
		sleepMode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("wake req", wakeupReq, 1'b1);
		check("irq asleep", supplyIrq, 1'b0);
		sleepMode <= 1'b0;
		apb(1'b0, reset_source_pkg::OFS_IRQ, 32'h0);
		check("irq flag", rd[0], 1'b1);
		env.setTrip(1, 1'b0);
		repeat (4) @(posedge ref_clk);
		apb(1'b1, reset_source_pkg::OFS_IRQ, 32'h1);
		repeat (3) @(posedge ref_clk);
		check("irq clear", supplyIrq, 1'b0);
		statusBit(reset_source_pkg::ST_IRQ0, "st irq");
		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h4);
		env.setTrip(1, 1'b1);
		waitLvl(1'b0, 10, "low reset");
		env.setTrip(1, 1'b0);
		waitLvl(1'b1, 40, "low end");
		statusBit(reset_source_pkg::ST_LVR, "st lvr");
		$display("test low voltage done");

		check("precise_supply_monitor on", presEnable, 1'b1);
		env.setTrip(5, 1'b1);
		waitLvl(1'b0, 10, "precise_supply_monitor reset");
		env.setTrip(5, 1'b0);
		waitLvl(1'b1, 40, "precise_supply_monitor end");
		env.setTrip(5, 1'b1);
		stay(1'b1, 12, "precise_supply_monitor rearm");
		env.setTrip(5, 1'b0);
		repeat (1100) @(posedge ref_clk);
		env.setTrip(5, 1'b1);
		waitLvl(1'b0, 10, "precise_supply_monitor again");
		env.setTrip(5, 1'b0);
		waitLvl(1'b1, 40, "precise_supply_monitor end2");
		statusBit(reset_source_pkg::ST_PRECISE_SUPPLY_MONITOR, "st precise_supply_monitor");
		$display("test precise done");

		hibernateMode <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("precise_supply_monitor off", presEnable, 1'b0);
		env.extPulse(20);
		check("ext hib", deviceResetN, 1'b0);
		waitLvl(1'b1, 30, "hib end");
		hibernateMode <= 1'b0;
		$display("test hibernate done");

		apb(1'b1, reset_source_pkg::OFS_WDT_TMO, 32'h64);
		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, reset_source_pkg::OFS_CTRL, 32'h0);
		apb(1'b0, reset_source_pkg::OFS_CTRL, 32'h0);
		check("wdt sticky", rd[0], 1'b1);
		repeat (4) begin
			repeat (50) @(posedge ref_clk);
			apb(1'b1, reset_source_pkg::OFS_WDT_KICK, 32'h0);
		end
		check("kicked", deviceResetN, 1'b1);
		waitLvl(1'b0, 140, "wdt bite");
		waitLvl(1'b1, 40, "wdt end");
		apb(1'b0, reset_source_pkg::OFS_CTRL, 32'h0);
		check("wdt kept", rd[0], 1'b1);
		apb(1'b0, reset_source_pkg::OFS_WDT_TMO, 32'h0);
		check("tmo back", rd, reset_source_pkg::WDT_TMO_RST);
		statusBit(reset_source_pkg::ST_WDT, "st wdt");
		$display("test watchdog done");
		summarize();
	end
endmodule // tb_reset_source_controller
